/* common/rtc_regs.svh */
// register indices, field positions and reset values of the radio configuration bank
`ifndef RTC_REGS_SVH
`define RTC_REGS_SVH
// register index; byte address is four times the index
`define RTC_IDX_PATTERN_CONTROL  6'h12
`define RTC_IDX_SLICER_THRESHOLD 6'h13
`define RTC_IDX_SIGNAL_STRENGTH  6'h14
`define RTC_IDX_PEAK_TRACKING    6'h15
`define RTC_IDX_PATTERN_FIRST    6'h16
`define RTC_IDX_PATTERN_SECOND   6'h17
`define RTC_IDX_PATTERN_THIRD    6'h18
`define RTC_IDX_PATTERN_FOURTH   6'h19
`define RTC_IDX_TRANSMITTER      6'h1A
// reset values
`define RTC_RST_PATTERN_CONTROL  8'h00
`define RTC_RST_SLICER_THRESHOLD 8'h0C
`define RTC_RST_PEAK_TRACKING    8'h00
`define RTC_RST_PATTERN_BYTE     8'h00
`define RTC_RST_TRANSMITTER      8'h70
// field positions
`define RTC_POS_DECAY       5
`define RTC_POS_UPDATE      2
`define RTC_POS_COEFF       0
`define RTC_POS_RECOG       5
`define RTC_POS_SIZE        3
`define RTC_POS_TOL         1
`define RTC_POS_CUTOFF      4
`define RTC_POS_POWER       1
// write mask of the transmitter register, bit 0 unused
`define RTC_MASK_TRANSMITTER 8'hFE
// sub-ticks per chip period
`define RTC_SUB_PER_CHIP    8'h10
`endif

/* common/rtc_pkg.sv */
// types shared by the radio configuration bank
package rtc_pkg;
   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [7:0]  paddr;
      logic [31:0] pwdata;
   } rtc_apb_req_type;

   typedef struct packed {
      logic       recog_enable;
      logic [1:0] pattern_size;
      logic [1:0] error_tolerance;
   } rtc_pattern_ctrl_type;

   typedef enum logic [1:0] {
      RTC_TX_IDLE  = 2'b01,
      RTC_TX_SHIFT = 2'b10
   } rtc_tx_state_type;
endpackage

/* design/rtc_config_bank.sv */
// configuration register bank with start-pattern transmit and detect logic
`timescale 1ns/10ps
`include "rtc_regs.svh"

module rtc_config_bank (
   // clock and reset
   input  wire logic                     I_CLK_SYS,
   input  wire logic                     I_RST,
   // apb slave
   input  wire rtc_pkg::rtc_apb_req_type I_APB,
   output logic                          O_PREADY,
   output logic                          O_PSLVERR,
   output logic [31:0]                   O_PRDATA,
   // analogue status in
   input  wire logic [7:0]               I_SIGNAL_STRENGTH,
   // bit timing enables, same clock
   input  wire logic                     I_SUB_TICK,
   input  wire logic                     I_BIT_TICK,
   // pattern transmit
   input  wire logic                     I_PATTERN_START,
   output logic                          O_PATTERN_BUSY,
   output logic                          O_PATTERN_BIT,
   output logic                          O_PATTERN_BIT_VALID,
   // pattern detect
   input  wire logic                     I_RX_BIT,
   input  wire logic                     I_RX_BIT_VALID,
   output logic                          O_PATTERN_MATCH,
   // receiver controls
   output logic [7:0]                    O_SLICER_THRESHOLD,
   output logic [3:0]                    O_PEAK_DECAY_HALF_DB,
   output logic                          O_PEAK_UPDATE,
   output logic [2:0]                    O_AVG_FILTER_SHIFT,
   // transmitter controls
   output logic [3:0]                    O_TX_ANTIALIAS_CUTOFF,
   output logic signed [4:0]             O_TX_POWER_DBM
);
   import rtc_pkg::*;

   // decay code to half-dB units
   function automatic logic [3:0] decay_half_db(input logic [2:0] code);
      logic [3:0] v;
      v = 4'h0;
      if (code[2]) begin
         v = 4'(({2'b00, code[1:0]} + 4'h3) << 1);
      end else begin
         v = 4'({2'b00, code[1:0]} + 4'h1);
      end
      return v;
   endfunction

   // update period in sub-ticks (16 per chip)
   function automatic logic [7:0] update_period(input logic [2:0] code);
      logic [7:0] p;
      p = 8'h00;
      if (code[2]) begin
         p = `RTC_SUB_PER_CHIP >> ({1'b0, code[1:0]} + 3'h1);
      end else begin
         p = `RTC_SUB_PER_CHIP << code[1:0];
      end
      return p;
   endfunction

   function automatic logic [5:0] count_ones(input logic [31:0] v);
      logic [5:0] n;
      n = 6'h00;
      for (int i = 0; i < 32; i++) begin
         n = n + {5'h00, v[i]};
      end
      return n;
   endfunction

   // registers
   logic [7:0]           slicer_threshold;
   logic [7:0]           peak_tracking_config;
   logic [7:0]           pattern_byte [4];
   logic [7:0]           transmitter_config;
   rtc_pattern_ctrl_type pattern_control;
   logic [7:0]           strength_meta;
   logic [7:0]           signal_strength_value;

   // apb decode
   wire       setup_phase = I_APB.psel & ~I_APB.penable;
   wire       access      = I_APB.psel & I_APB.penable;
   wire [5:0] reg_index   = I_APB.paddr[7:2];
   wire       aligned     = (I_APB.paddr[1:0] == 2'b00);
   wire       hit_pctl    = aligned & (reg_index == `RTC_IDX_PATTERN_CONTROL);
   wire       hit_slicer  = aligned & (reg_index == `RTC_IDX_SLICER_THRESHOLD);
   wire       hit_strength = aligned & (reg_index == `RTC_IDX_SIGNAL_STRENGTH);
   wire       hit_peak    = aligned & (reg_index == `RTC_IDX_PEAK_TRACKING);
   wire       hit_pattern = aligned & (reg_index >= `RTC_IDX_PATTERN_FIRST)
                            & (reg_index <= `RTC_IDX_PATTERN_FOURTH);
   wire       hit_tx      = aligned & (reg_index == `RTC_IDX_TRANSMITTER);
   wire       mapped      = hit_pctl | hit_slicer | hit_strength | hit_peak
                            | hit_pattern | hit_tx;
   wire [1:0] pat_sel     = 2'(reg_index - `RTC_IDX_PATTERN_FIRST);
   wire       wr_en       = access & I_APB.pwrite;
   wire [7:0] wbyte       = I_APB.pwdata[7:0];

   logic [7:0] rd_mux;
   always_comb begin
      rd_mux = 8'h00;
      if (hit_pctl) begin
         rd_mux = {2'b00, pattern_control, 1'b0};
      end else if (hit_slicer) begin
         rd_mux = slicer_threshold;
      end else if (hit_strength) begin
         rd_mux = signal_strength_value;
      end else if (hit_peak) begin
         rd_mux = peak_tracking_config;
      end else if (hit_pattern) begin
         rd_mux = pattern_byte[pat_sel];
      end else if (hit_tx) begin
         rd_mux = transmitter_config;
      end
   end

   // zero wait states; unmapped addresses answer with an error
   assign O_PREADY  = 1'b1;
   assign O_PSLVERR = access & ~mapped;

   always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
      if (I_RST) begin
         O_PRDATA <= 32'h0000_0000;
      end else if (setup_phase & ~I_APB.pwrite) begin
         O_PRDATA <= {24'h00_0000, rd_mux};
      end
   end

   always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
      if (I_RST) begin
         slicer_threshold     <= `RTC_RST_SLICER_THRESHOLD;
         peak_tracking_config <= `RTC_RST_PEAK_TRACKING;
         transmitter_config   <= `RTC_RST_TRANSMITTER;
         pattern_control      <= 5'(`RTC_RST_PATTERN_CONTROL >> 1);
         for (int i = 0; i < 4; i++) begin
            pattern_byte[i] <= `RTC_RST_PATTERN_BYTE;
         end
      end else if (wr_en) begin
         if (hit_slicer) begin
            slicer_threshold <= wbyte;
         end
         if (hit_peak) begin
            peak_tracking_config <= wbyte;
         end
         if (hit_pattern) begin
            pattern_byte[pat_sel] <= wbyte;
         end
         if (hit_tx) begin
            transmitter_config <= wbyte & `RTC_MASK_TRANSMITTER;
         end
         if (hit_pctl) begin
            pattern_control <= wbyte[5:1];
         end
      end
   end

   // signal strength arrives from the analogue side, two flops before use
   always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
      if (I_RST) begin
         strength_meta         <= 8'h00;
         signal_strength_value <= 8'h00;
      end else begin
         strength_meta         <= I_SIGNAL_STRENGTH;
         signal_strength_value <= strength_meta;
      end
   end

   // receiver and transmitter decoded controls
   wire [2:0] decay_code  = peak_tracking_config[`RTC_POS_DECAY +: 3];
   wire [2:0] update_code = peak_tracking_config[`RTC_POS_UPDATE +: 3];
   wire [1:0] coeff_code  = peak_tracking_config[`RTC_POS_COEFF +: 2];
   wire [2:0] power_code  = transmitter_config[`RTC_POS_POWER +: 3];

   assign O_SLICER_THRESHOLD    = slicer_threshold;
   assign O_PEAK_DECAY_HALF_DB  = decay_half_db(decay_code);
   assign O_AVG_FILTER_SHIFT    = (coeff_code == 2'b00) ? 3'h5 :
                                  3'(3'h4 - {1'b0, coeff_code});
   assign O_TX_ANTIALIAS_CUTOFF = transmitter_config[`RTC_POS_CUTOFF +: 4];
   assign O_TX_POWER_DBM        = 5'(5'sd13 - 5'($signed({2'b00, power_code}) * 3));

   // peak update pacing on the 16x chip sub-tick
   logic [7:0] update_count;
   wire  [7:0] period     = update_period(update_code);
   wire        update_due = I_SUB_TICK & (update_count >= 8'(period - 8'h01));

   always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
      if (I_RST) begin
         update_count  <= 8'h00;
         O_PEAK_UPDATE <= 1'b0;
      end else begin
         O_PEAK_UPDATE <= update_due;
         if (update_due) begin
            update_count <= 8'h00;
         end else if (I_SUB_TICK) begin
            update_count <= update_count + 8'h01;
         end
      end
   end

   // pattern as one word, first byte most significant
   wire [31:0] pattern_word = {pattern_byte[0], pattern_byte[1],
                               pattern_byte[2], pattern_byte[3]};
   wire [5:0]  pattern_bits = 6'({pattern_control.pattern_size, 3'b000} + 6'h08);

   // transmit serializer
   rtc_tx_state_type tx_state;
   rtc_tx_state_type next_tx_state;
   logic [31:0]      tx_shift;
   logic [5:0]       tx_left;

   always_comb begin
      next_tx_state = tx_state;
      case (tx_state)
         RTC_TX_IDLE: begin
            if (I_PATTERN_START) begin
               next_tx_state = RTC_TX_SHIFT;
            end
         end
         RTC_TX_SHIFT: begin
            if (I_BIT_TICK && tx_left == 6'h01) begin
               next_tx_state = RTC_TX_IDLE;
            end
         end
         default: next_tx_state = RTC_TX_IDLE;
      endcase
   end

   always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
      if (I_RST) begin
         tx_state            <= RTC_TX_IDLE;
         tx_shift            <= 32'h0000_0000;
         tx_left             <= 6'h00;
         O_PATTERN_BIT       <= 1'b0;
         O_PATTERN_BIT_VALID <= 1'b0;
      end else begin
         tx_state            <= next_tx_state;
         O_PATTERN_BIT_VALID <= 1'b0;
         if (tx_state == RTC_TX_IDLE && I_PATTERN_START) begin
            tx_shift <= pattern_word;
            tx_left  <= pattern_bits;
         end else if (tx_state == RTC_TX_SHIFT && I_BIT_TICK) begin
            O_PATTERN_BIT       <= tx_shift[31];
            O_PATTERN_BIT_VALID <= 1'b1;
            tx_shift            <= {tx_shift[30:0], 1'b0};
            tx_left             <= tx_left - 6'h01;
         end
      end
   end

   assign O_PATTERN_BUSY = (tx_state == RTC_TX_SHIFT);

   // receive detection over the last 8..32 bits
   logic [31:0] rx_shift;
   logic [5:0]  rx_seen;
   wire  [4:0]  drop      = 5'({~pattern_control.pattern_size, 3'b000});
   wire  [31:0] expect_w  = pattern_word >> drop;
   wire  [31:0] mask_w    = 32'hFFFF_FFFF >> drop;
   wire  [5:0]  bit_errs  = count_ones((rx_shift ^ expect_w) & mask_w);
   wire         full_seen = (rx_seen >= pattern_bits);
   wire         accept    = pattern_control.recog_enable & full_seen
                            & (bit_errs <= {4'h0, pattern_control.error_tolerance});

   always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
      if (I_RST) begin
         rx_shift        <= 32'h0000_0000;
         rx_seen         <= 6'h00;
         O_PATTERN_MATCH <= 1'b0;
      end else begin
         O_PATTERN_MATCH <= 1'b0;
         if (!pattern_control.recog_enable) begin
            rx_seen <= 6'h00;
         end else if (I_RX_BIT_VALID) begin
            rx_shift <= {rx_shift[30:0], I_RX_BIT};
            if (rx_seen != 6'h20) begin
               rx_seen <= rx_seen + 6'h01;
            end
         end else if (accept) begin
            O_PATTERN_MATCH <= 1'b1;
            rx_seen         <= 6'h00;
         end
      end
   end

   // checks
   default clocking cb @(posedge I_CLK_SYS); endclocking
   default disable iff (I_RST);

   a_slicer_write_lands: assert property (
      wr_en && hit_slicer |=> O_SLICER_THRESHOLD == $past(wbyte))
      else $error("slicer threshold did not take the written byte");
   a_decay_top_code: assert property (
      decay_code == 3'b111 |-> O_PEAK_DECAY_HALF_DB == 4'hC)
      else $error("decay code 111 is not 6 dB");
   a_update_fast_rate: assert property (
      update_code == 3'b111 && I_SUB_TICK && !wr_en |=> O_PEAK_UPDATE)
      else $error("16x update rate missed a sub-tick");
   a_coeff_slowest: assert property (
      coeff_code == 2'b00 |-> O_AVG_FILTER_SHIFT == 3'h5)
      else $error("coefficient 00 is not divide by 32");
   a_first_bit_msb: assert property (
      tx_state == RTC_TX_IDLE && I_PATTERN_START ##1 I_BIT_TICK
      |=> O_PATTERN_BIT_VALID && O_PATTERN_BIT == $past(tx_shift[31]))
      else $error("first transmitted bit is not the top of the first byte");
   a_pattern_readback: assert property (
      setup_phase && !I_APB.pwrite && hit_pattern
      |=> O_PRDATA[7:0] == pattern_byte[$past(pat_sel)])
      else $error("pattern byte read back wrong");
   a_power_bottom: assert property (
      power_code == 3'b111 |-> O_TX_POWER_DBM == -5'sd8)
      else $error("power code 111 is not -8 dBm");
   a_tx_bit_zero: assert property (
      transmitter_config[0] == 1'b0)
      else $error("unused transmitter bit is set");
   a_no_match_disabled: assert property (
      !pattern_control.recog_enable |=> !O_PATTERN_MATCH)
      else $error("match reported while detection disabled");
   a_match_tolerance: assert property (
      O_PATTERN_MATCH |-> $past(bit_errs) <= {4'h0, $past(pattern_control.error_tolerance)})
      else $error("match accepted too many bit errors");

endmodule // rtc_config_bank

/* bench/rtc_apb_host.sv */
// apb host model that configures the radio bank
`timescale 1ns/10ps
module rtc_apb_host (
   // clock
   input  wire logic                     i_clk,
   // slave answer
   input  wire logic                     i_pready,
   input  wire logic                     i_pslverr,
   input  wire logic [31:0]              i_prdata,
   // request
   output rtc_pkg::rtc_apb_req_type      o_req
);
   import rtc_pkg::*;
   initial o_req = '0;
   // psel and penable drop to zero; write, address and data lines carry inverted values so stale data never looks valid
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
      @(posedge i_clk);
      o_req <= '{1'b1, 1'b0, w, a, d};
      @(posedge i_clk);
      o_req.penable <= 1'b1;
      // no local limit: a slave that never answers is caught by the bench timeout
      do begin
         @(posedge i_clk);
      end while (i_pready !== 1'b1);
      rd = i_prdata;
      err = i_pslverr;
      o_req <= '{1'b0, 1'b0, ~w, ~a, ~d};
   endtask
endmodule // rtc_apb_host

/* bench/tb.sv */
// self-checking bench of the radio configuration bank
`timescale 1ns/10ps
`include "rtc_regs.svh"
module tb;
   import rtc_pkg::*;
   logic              clk, rst, pready, pslverr, sub_tick, bit_tick, start, busy;
   logic              tx_bit, tx_valid, rx_bit, rx_valid, match, upd;
   logic [31:0]       prdata;
   logic [7:0]        rssi, slicer;
   logic [3:0]        decay, cutoff;
   logic [2:0]        shift;
   logic signed [4:0] pwr;
   rtc_apb_req_type   req;
   int                n_errors = 0;
   int                n_tests = 0;
   int                cycles = 0;
   localparam logic [31:0] PAT = 32'hC35A960F;
   localparam logic [3:0] DEC [8] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h8, 4'hA, 4'hC};
   localparam logic [2:0] SHF [4] = '{3'h5, 3'h3, 3'h2, 3'h1};

   rtc_apb_host u_host (.i_clk(clk), .i_pready(pready), .i_pslverr(pslverr),
      .i_prdata(prdata), .o_req(req));
   rtc_config_bank u_dut (.I_CLK_SYS(clk), .I_RST(rst), .I_APB(req), .O_PREADY(pready),
      .O_PSLVERR(pslverr), .O_PRDATA(prdata), .I_SIGNAL_STRENGTH(rssi),
      .I_SUB_TICK(sub_tick), .I_BIT_TICK(bit_tick), .I_PATTERN_START(start),
      .O_PATTERN_BUSY(busy), .O_PATTERN_BIT(tx_bit), .O_PATTERN_BIT_VALID(tx_valid),
      .I_RX_BIT(rx_bit), .I_RX_BIT_VALID(rx_valid), .O_PATTERN_MATCH(match),
      .O_SLICER_THRESHOLD(slicer), .O_PEAK_DECAY_HALF_DB(decay), .O_PEAK_UPDATE(upd),
      .O_AVG_FILTER_SHIFT(shift), .O_TX_ANTIALIAS_CUTOFF(cutoff), .O_TX_POWER_DBM(pwr));

   function automatic logic [7:0] ba(input logic [5:0] i);
      return {i, 2'b00};
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] rd;
      logic        e;
      u_host.xfer(1'b1, a, {24'h0, d}, rd, e);
      // the write lands at the access edge; decoded outputs settle after it
      @(posedge clk);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic exp_err);
      logic [31:0] rd;
      logic        e;
      u_host.xfer(1'b0, a, 32'h0, rd, e);
      chk(rd, exp);
      chk({31'h0, e}, {31'h0, exp_err});
   endtask
   task automatic wait_upd(output int n);
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (upd !== 1'b1 && n < 300);
   endtask

   task automatic t_reset;
      rd_chk(ba(`RTC_IDX_SLICER_THRESHOLD), 32'h0C, 1'b0);
      rd_chk(ba(`RTC_IDX_PEAK_TRACKING), 32'h00, 1'b0);
      for (int i = 0; i < 4; i++) rd_chk(ba(6'(`RTC_IDX_PATTERN_FIRST + i)), 32'h0, 1'b0);
      rd_chk(ba(`RTC_IDX_TRANSMITTER), 32'h70, 1'b0);
      rd_chk(ba(`RTC_IDX_SIGNAL_STRENGTH), 32'h5A, 1'b0);
      chk({24'h0, slicer}, 32'h0C);
      chk({28'h0, cutoff}, 32'h7);
      chk({27'h0, pwr}, 32'hD);
      $display("test reset done");
   endtask
   task automatic t_access;
      for (int i = 0; i < 4; i++) wr(ba(6'(`RTC_IDX_PATTERN_FIRST + i)), PAT[31-8*i -: 8]);
      for (int i = 0; i < 4; i++) begin
         rd_chk(ba(6'(`RTC_IDX_PATTERN_FIRST + i)), {24'h0, PAT[31-8*i -: 8]}, 1'b0);
      end
      wr(ba(`RTC_IDX_SLICER_THRESHOLD), 8'hA7);
      rd_chk(ba(`RTC_IDX_SLICER_THRESHOLD), 32'hA7, 1'b0);
      chk({24'h0, slicer}, 32'hA7);
      wr(ba(`RTC_IDX_SIGNAL_STRENGTH), 8'hFF);
      rd_chk(ba(`RTC_IDX_SIGNAL_STRENGTH), 32'h5A, 1'b0);
      rd_chk(8'h00, 32'h0, 1'b1);
      rd_chk(8'h4D, 32'h0, 1'b1);
      for (int c = 0; c < 8; c++) begin
         wr(ba(`RTC_IDX_TRANSMITTER), {4'(15 - c), 3'(c), 1'b1});
         rd_chk(ba(`RTC_IDX_TRANSMITTER), {24'h0, 4'(15 - c), 3'(c), 1'b0}, 1'b0);
         chk({28'h0, cutoff}, {28'h0, 4'(15 - c)});
         chk({27'h0, pwr}, {27'h0, 5'(13 - 3 * c)});
      end
      $display("test access done");
   endtask
   task automatic t_peak;
      int n;
      for (int u = 0; u < 8; u++) begin
         wr(ba(`RTC_IDX_PEAK_TRACKING), {3'(u), 3'(u), 2'(u)});
         chk({28'h0, decay}, {28'h0, DEC[u]});
         chk({29'h0, shift}, {29'h0, SHF[u % 4]});
         wait_upd(n);
         wait_upd(n);
         chk(32'(n), u < 4 ? 32'(16 << u) : 32'(16 >> (u - 3)));
      end
      $display("test peak done");
   endtask
   task automatic t_tx;
      logic [31:0] got;
      int          k, n, sz;
      for (int j = 0; j < 2; j++) begin
         sz = 3 * j;
         wr(ba(`RTC_IDX_PATTERN_CONTROL), {3'h0, 2'(sz), 3'h0});
         start <= 1'b1;
         @(posedge clk);
         start <= 1'b0;
         bit_tick <= 1'b1;
         got = 32'h0;
         k = 0;
         n = 0;
         while (k < 8 * (sz + 1) && n < 100) begin
            @(posedge clk);
            n++;
            if (n == 1) chk({31'h0, busy}, 32'h1);
            if (tx_valid === 1'b1) begin
               got = {got[30:0], tx_bit};
               k++;
            end
         end
         bit_tick <= 1'b0;
         @(posedge clk);
         chk(got, PAT >> (8 * (3 - sz)));
         chk({31'h0, busy}, 32'h0);
      end
      $display("test transmit done");
   endtask
   task automatic rx_try(input logic [7:0] b, input logic exp);
      logic m;
      for (int i = 7; i >= 0; i--) begin
         rx_bit <= b[i];
         rx_valid <= 1'b1;
         @(posedge clk);
      end
      rx_valid <= 1'b0;
      m = 1'b0;
      repeat (4) begin
         @(posedge clk);
         if (match === 1'b1) m = 1'b1;
      end
      chk({31'h0, m}, {31'h0, exp});
   endtask
   task automatic t_detect;
      wr(ba(`RTC_IDX_PATTERN_CONTROL), 8'h22);
      rx_try(8'hC3, 1'b1);
      rx_try(8'hC2, 1'b1);
      rx_try(8'hC0, 1'b0);
      wr(ba(`RTC_IDX_PATTERN_CONTROL), 8'h26);
      rx_try(8'hC4, 1'b1);
      wr(ba(`RTC_IDX_PATTERN_CONTROL), 8'h00);
      rx_try(8'hC3, 1'b0);
      wr(ba(`RTC_IDX_PATTERN_CONTROL), 8'h28);
      rx_try(8'hC3, 1'b0);
      rx_try(8'h5A, 1'b1);
      $display("test detect done");
   endtask
   task automatic stop_test;
      $display("checks=%0d mismatches=%0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // the longest test needs a few hundred cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles > 20000) begin
         n_errors++;
         stop_test;
      end
   end
   initial begin
      rst = 1'b1;
      sub_tick = 1'b1;
      bit_tick = 1'b0;
      start = 1'b0;
      rx_bit = 1'b0;
      rx_valid = 1'b0;
      rssi = 8'h5A;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      t_reset;
      t_access;
      t_peak;
      t_tx;
      t_detect;
      stop_test;
   end
endmodule // tb
